// ### common/dcas_pkg.sv
// Package for the dual channel converter serial port
package dcas_pkg;
    localparam int RES_BITS = 12;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] BIT_CNT_LAST = 5'h10;
    localparam logic [1:0] CHAN_SEL_POS = 2'h2;
    localparam logic [RES_BITS-1:0] SAMPLE_RESET = 12'h000;

    typedef enum logic [1:0] {
        DCAS_IDLE = 2'b00,
        DCAS_SHIFT = 2'b01,
        DCAS_DONE = 2'b10
    } dcas_state_t;

    // Serial pins seen from the device
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic sdi;
    } dcas_pins_in_t;

    // Converter sample handed in by the analog front end
    typedef struct packed {
        logic [RES_BITS-1:0] chan0;
        logic [RES_BITS-1:0] chan1;
    } dcas_samples_t;
endpackage : dcas_pkg

// ### core/dcas_port.sv
// Serial conversion and readout port of a two channel converter
`timescale 1ns/10ps
// How it works
// - Serial input bits are captured on serial clock falling edges.
// - Output advances to next bit after each serial clock falling edge.
// - Output leaves high impedance once frame select goes low.
// - Output floats again after the falling edge ending the transfer.
// - Conversion completes within 16 serial clock cycles.
// - Frame select falling edge starts conversion and frames one transfer.
// - Third most significant input bit picks the channel.
// - Output sends two zeros, channel id, duplicate, result MSB first.
module dcas_port
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial pins
    input wire dcas_pkg::dcas_pins_in_t pins,
    output logic sdo_out,
    output logic sdo_oe_n,
    // Analog front end
    input wire dcas_pkg::dcas_samples_t samples,
    output logic conv_done,
    output logic conv_chan
);
    import dcas_pkg::*;

    typedef struct packed {
        dcas_pins_in_t sync1;
        dcas_pins_in_t sync2;
        logic sclk_last;
        logic frame_last;
        dcas_state_t state;
        logic [4:0] bit_cnt;
        logic [2:0] din_shift;
        logic chan;
        logic [FRAME_BITS-1:0] out_shift;
        logic sdo;
        logic oe_n;
        logic done;
    } dcas_regs_t;

    dcas_regs_t st_reg;
    dcas_regs_t st_next;
    logic sclk_fall;
    logic frame_fall;

    // Result word of one channel, picked by the channel register
    function automatic logic [RES_BITS-1:0] pick_sample(input dcas_samples_t s, input logic ch);
        logic [RES_BITS-1:0] word;
        if (ch)
            word = s.chan1;
        else
            word = s.chan0;
        return word;
    endfunction : pick_sample

    assign sclk_fall = st_reg.sclk_last & ~st_reg.sync2.sclk;
    assign frame_fall = st_reg.frame_last & ~st_reg.sync2.frame_n;

    always_comb
    begin
        st_next = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.sclk_last = st_reg.sync2.sclk;
        st_next.frame_last = st_reg.sync2.frame_n;
        st_next.done = 1'b0;
        if (st_reg.sync2.frame_n)
        begin
            // Frame abort floats the line at once
            st_next.state = DCAS_IDLE;
            st_next.oe_n = 1'b1;
        end
        else
        begin
            case (st_reg.state)
                DCAS_IDLE:
                begin
                    if (frame_fall)
                    begin
                        // Sampled at frame start, so a pick only steers the next frame
                        st_next.state = DCAS_SHIFT;
                        st_next.bit_cnt = 5'h00;
                        st_next.din_shift = 3'h0;
                        st_next.oe_n = 1'b0;
                        st_next.sdo = 1'b0;
                        st_next.out_shift = {1'b0, st_reg.chan, st_reg.chan,
                            pick_sample(samples, st_reg.chan), 1'b0};
                    end
                end
                DCAS_SHIFT:
                begin
                    if (sclk_fall)
                    begin
                        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt < 5'h03)
                            st_next.din_shift = {st_reg.din_shift[1:0], st_reg.sync2.sdi};
                        // Third capture holds the channel pick
                        if (st_reg.bit_cnt == {3'h0, CHAN_SEL_POS})
                            st_next.chan = st_reg.sync2.sdi;
                        st_next.sdo = st_reg.out_shift[FRAME_BITS-1];
                        st_next.out_shift = {st_reg.out_shift[FRAME_BITS-2:0], 1'b0};
                        if (st_reg.bit_cnt == BIT_CNT_LAST - 5'h01)
                        begin
                            st_next.state = DCAS_DONE;
                            st_next.oe_n = 1'b1;
                            st_next.done = 1'b1;
                        end
                    end
                end
                DCAS_DONE:
                begin
                    st_next.oe_n = 1'b1;
                end
                default:
                begin
                    st_next.state = DCAS_IDLE;
                    st_next.oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Pin idle levels, so no false edge follows reset
            st_reg <= '{sync1: 3'h4, sync2: 3'h4, sclk_last: 1'b0, frame_last: 1'b1,
                state: DCAS_IDLE, bit_cnt: 5'h00, din_shift: 3'h0, chan: 1'b0,
                out_shift: 16'h0000, sdo: 1'b0, oe_n: 1'b1, done: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign sdo_out = st_reg.sdo;
    assign sdo_oe_n = st_reg.oe_n;
    assign conv_done = st_reg.done;
    assign conv_chan = st_reg.chan;

    // Frame select high means floating output
    idle_float_a: assert property (@(posedge clk) disable iff (!reset_n)
        st_reg.sync2.frame_n |=> sdo_oe_n)
        else $error("output driven outside frame");

    frame_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_fall && st_reg.state == DCAS_IDLE) |=> !sdo_oe_n)
        else $error("output not driven after frame start");

    // No frame fall, no transfer
    idle_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_reg.state == DCAS_IDLE && !frame_fall) |=> (sdo_oe_n && st_reg.state == DCAS_IDLE))
        else $error("transfer without frame start");

    // A cut frame ends without a result
    abort_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_reg.sync2.frame_n && st_reg.state != DCAS_IDLE) |=> (st_reg.state == DCAS_IDLE && !conv_done))
        else $error("cut frame not ended");

    end_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sclk_fall && !st_reg.sync2.frame_n && st_reg.state == DCAS_SHIFT
            && st_reg.bit_cnt == 5'h0F) |=> (sdo_oe_n && conv_done))
        else $error("output not released at transfer end");

    // Late clock falls must not drive the line again
    done_float_a: assert property (@(posedge clk) disable iff (!reset_n)
        st_reg.state == DCAS_DONE |=> sdo_oe_n)
        else $error("output driven after transfer end");

    lead_zeros_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_reg.state == DCAS_SHIFT && st_reg.bit_cnt < 5'h02 && !sdo_oe_n) |-> !sdo_out)
        else $error("leading bits not zero");

    // Id pair names the channel sampled at frame start
    id_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_fall && st_reg.state == DCAS_IDLE)
        |=> (st_reg.out_shift[FRAME_BITS-1:FRAME_BITS-3] == {1'b0, conv_chan, conv_chan}))
        else $error("channel id not loaded");

    chan_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n && st_reg.bit_cnt == 5'h02)
        |=> (conv_chan == $past(st_reg.sync2.sdi)))
        else $error("channel not taken from third bit");

    chan_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n && st_reg.bit_cnt == 5'h02)
        |=> $stable(conv_chan))
        else $error("channel changed outside its slot");

    bit_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n)
        |=> (sdo_out == $past(st_reg.out_shift[FRAME_BITS-1])))
        else $error("output did not advance");

    // Output bit stands until the next detected fall
    bit_stand_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n) |=> $stable(sdo_out))
        else $error("output moved between clock falls");

    conv_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        conv_done |-> $past(st_reg.bit_cnt) == 5'h0F)
        else $error("conversion length wrong");

    fall_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n)
        |=> (st_reg.bit_cnt == $past(st_reg.bit_cnt) + 5'h01))
        else $error("fall count did not step");

    done_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        conv_done |=> !conv_done)
        else $error("done pulse too long");

    din_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n && st_reg.bit_cnt == 5'h00)
        |=> st_reg.din_shift[0] == $past(st_reg.sync2.sdi))
        else $error("input bit not captured");

    // The second capture shifts the first bit up
    din_next_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sclk_fall && st_reg.state == DCAS_SHIFT && !st_reg.sync2.frame_n && st_reg.bit_cnt == 5'h01)
        |=> (st_reg.din_shift[1:0] == {$past(st_reg.din_shift[0]), $past(st_reg.sync2.sdi)}))
        else $error("input bits not shifted");
endmodule : dcas_port

// ### tb/dcas_host.sv
// Host serial master model that frames conversions on the port
`timescale 1ns/10ps
module dcas_host
import dcas_pkg::*;
(
    // Clock
    input wire logic clk,
    // Serial pins
    output dcas_pins_in_t pins,
    input wire logic sdo_wire
);
    initial pins = '{frame_n: 1'h1, sclk: 1'h0, sdi: 1'h0};
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Clock idles low, so no fall is seen outside a frame
    task automatic frame(input logic sel, input int n, output logic [15:0] q, output logic tail);
        pins.frame_n = 1'h0;
        tick(4);
        for (int k = 1; k <= n; k++)
        begin
            // Other bits inverted so a wrong capture slot shows
            pins.sdi = (k == 3) ? sel : ~sel;
            pins.sclk = 1'h1;
            tick(4);
            if (k <= 16)
                q[16-k] = sdo_wire;
            pins.sclk = 1'h0;
            tick(4);
        end
        tick(4);
        tail = sdo_wire;
        pins.frame_n = 1'h1;
        pins.sdi = 1'h0;
        tick(12);
    endtask : frame
endmodule : dcas_host

// ### tb/dcas_port_bench.sv
// Self-checking bench for the converter serial port
`timescale 1ns/10ps
module dcas_port_bench;
    import dcas_pkg::*;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    dcas_pins_in_t pins;
    dcas_samples_t samples = '{chan0: 12'hA5C, chan1: 12'h3B6};
    logic sdo_out, sdo_oe_n, conv_done, conv_chan;
    // No pull on the data line, so a float reads as Z
    wire sdo_wire = sdo_oe_n ? 1'hZ : sdo_out;
    int fail_count = 0;
    int n_tests = 0;
    int done_cnt = 0;
    logic [15:0] q;
    logic tail;
    // Sample is taken at frame start, so a pick steers the next frame
    logic cur_chan = 1'h0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (conv_done === 1'h1) done_cnt++;
    dcas_port uut (.clk(clk), .reset_n(reset_n), .pins(pins), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .samples(samples), .conv_done(conv_done), .conv_chan(conv_chan));
    dcas_host host (.clk(clk), .pins(pins), .sdo_wire(sdo_wire));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic test_frame(input logic sel, input int n);
        int d0;
        logic [11:0] word;
        d0 = done_cnt;
        word = cur_chan ? samples.chan1 : samples.chan0;
        host.frame(sel, n, q, tail);
        check(q, {2'h0, cur_chan, cur_chan, word}, "frame bits");
        check(tail, 1'hZ, "release after last fall");
        check(16'(done_cnt - d0), 16'h1, "one conversion");
        check(conv_chan, sel, "channel");
        check(sdo_wire, 1'hZ, "idle float");
        cur_chan = sel;
        $display("Frame test done: channel %0d, %0d falls", sel, n);
    endtask : test_frame
    task automatic test_abort;
        int d0;
        logic [11:0] word;
        d0 = done_cnt;
        word = cur_chan ? samples.chan1 : samples.chan0;
        host.frame(1'h1, 5, q, tail);
        check(q[15:11], {2'h0, cur_chan, cur_chan, word[11]}, "partial bits");
        check(tail, word[10], "driven until frame ends");
        check(sdo_wire, 1'hZ, "float on abort");
        check(16'(done_cnt - d0), 16'h0, "no conversion");
        check(conv_chan, 1'h1, "channel from cut frame");
        cur_chan = 1'h1;
        $display("Abort test done");
    endtask : test_abort
    initial
    begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        check({sdo_oe_n, conv_done, conv_chan, sdo_out}, 16'h8, "reset outputs");
        reset_n = 1'h1;
        host.tick(8);
        test_frame(1'h0, 16);
        test_frame(1'h1, 16);
        test_abort();
        test_frame(1'h0, 18);
        samples = '{chan0: 12'h001, chan1: 12'hFFE};
        test_frame(1'h1, 16);
        test_frame(1'h0, 16);
        stop_test();
    end
endmodule : dcas_port_bench
